// File: flash_port_dev.sv
// device end: identity strap, lane order, boot busy, access width
// assumes a shared bus with at most one peer device
//
// Operation
// - two devices share bus, strap differs
// - strap low first device, high second
// - little endian: D[7:0] is low byte
// - swap bits exchange the byte lanes
// - busy low while boot copy runs
// - host may wait on busy first
// - busy never shows flash activity
// - 16-bit default, 32-bit only when configured
// - word mode moves full 16-bit words
// - 32-bit host wires A1 from SA2
// - no wait states without host wait
`timescale 1ns/10ps
`default_nettype none
module flash_port_dev
	import host_bus_pkg::*;
#(
	parameter int BOOT_CYC = BOOT_COPY_CYC
)
(
	input wire logic clk,
	input wire logic resetn,
	host_bus_if.device bus,
	input wire logic identityStrap,
	output logic bootDone,
	output logic wideMode,
	output logic [DATA_W-1:0] scratchWord
);
	typedef enum logic [2:0] {
		BOOT = 3'b001,
		IDLE = 3'b010,
		DRIVE = 3'b100
	} dev_state_e;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] strapSync_reg;
	logic [1:0] ceSync_reg, oeSync_reg, weSync_reg;
	logic [ADDR_W-1:0] addrS1_reg, addrS2_reg;
	logic [DATA_W-1:0] dataS1_reg, dataS2_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			strapSync_reg <= 2'h0;
			ceSync_reg <= 2'h3;
			oeSync_reg <= 2'h3;
			weSync_reg <= 2'h3;
			addrS1_reg <= 8'h00;
			addrS2_reg <= 8'h00;
			dataS1_reg <= 16'h0000;
			dataS2_reg <= 16'h0000;
		end else begin
			strapSync_reg <= {strapSync_reg[0], identityStrap};
			ceSync_reg <= {ceSync_reg[0], bus.ceN};
			oeSync_reg <= {oeSync_reg[0], bus.oeN};
			weSync_reg <= {weSync_reg[0], bus.weN};
			addrS1_reg <= bus.addr;
			addrS2_reg <= addrS1_reg;
			dataS1_reg <= bus.dataLine;
			dataS2_reg <= dataS1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state and registers
	dev_state_e state_reg, state_next;
	logic [15:0] bootCnt_reg, bootCnt_next;
	logic myId_reg, myId_next;
	logic [15:0] endian_reg, endian_next;
	logic [15:0] config_reg, config_next;
	logic [15:0] scratch_reg, scratch_next;
	logic [15:0] hiHalf_reg, hiHalf_next;
	logic weDly_reg, weDly_next;
	logic [15:0] devOut_reg, devOut_next;
	logic devOe_reg, devOe_next;
	logic busyN_reg, busyN_next;
	logic [DATA_W-1:0] rdCore, rdPin, wrCore;
	logic selected, weFall;

	lane_swap u_swap_rd (
		.swapEn(endian_reg == SWAP_BITS),
		.dIn(rdCore),
		.dOut(rdPin)
	);
	lane_swap u_swap_wr (
		.swapEn(endian_reg == SWAP_BITS),
		.dIn(dataS2_reg),
		.dOut(wrCore)
	);

	// device select: top address bit carries identity
	function automatic logic isMine(input logic [ADDR_W-1:0] a, input logic id);
		return a[ADDR_W-1] == id;
	endfunction : isMine

	always_comb begin
		selected = !ceSync_reg[1] && isMine(addrS2_reg, myId_reg);
		weFall = weDly_reg && !weSync_reg[1];
		unique case (addrS2_reg[1:0])
			OFS_ENDIAN[1:0]: rdCore = endian_reg;
			OFS_CONFIG[1:0]: rdCore = config_reg;
			OFS_SCRATCH[1:0]: rdCore = (config_reg[CFG_WIDE_BIT] && addrS2_reg[2]) ? hiHalf_reg : scratch_reg;
			default: rdCore = {15'h0000, busyN_reg};
		endcase
	end

	always_comb begin
		state_next = state_reg;
		bootCnt_next = bootCnt_reg;
		myId_next = myId_reg;
		endian_next = endian_reg;
		config_next = config_reg;
		scratch_next = scratch_reg;
		hiHalf_next = hiHalf_reg;
		weDly_next = weSync_reg[1];
		devOut_next = devOut_reg;
		devOe_next = 1'b0;
		busyN_next = busyN_reg;
		unique case (state_reg)
			BOOT: begin
				busyN_next = 1'b0;
				myId_next = strapSync_reg[1];
				if (bootCnt_reg >= 16'(BOOT_CYC - 1)) begin
					busyN_next = 1'b1;
					state_next = IDLE;
				end else begin
					bootCnt_next = bootCnt_reg + 16'h0001;
				end
			end
			IDLE, DRIVE: begin
				// busy stays released; flash work never re-asserts it
				busyN_next = 1'b1;
				state_next = IDLE;
				if (selected && weFall) begin
					// whole word only, no byte strobes
					unique case (addrS2_reg[1:0])
						OFS_ENDIAN[1:0]: endian_next = wrCore;
						OFS_CONFIG[1:0]: config_next = wrCore;
						OFS_SCRATCH[1:0]: begin
							if (config_reg[CFG_WIDE_BIT] && addrS2_reg[2])
								hiHalf_next = wrCore;
							else
								scratch_next = wrCore;
						end
						default: ;
					endcase
				end
				if (selected && !oeSync_reg[1]) begin
					devOut_next = rdPin;
					devOe_next = 1'b1;
					state_next = DRIVE;
				end
			end
			default: state_next = BOOT;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= BOOT;
			bootCnt_reg <= 16'h0000;
			myId_reg <= 1'b0;
			endian_reg <= ENDIAN_RST;
			config_reg <= CONFIG_RST;
			scratch_reg <= 16'h0000;
			hiHalf_reg <= 16'h0000;
			weDly_reg <= 1'b1;
			devOut_reg <= 16'h0000;
			devOe_reg <= 1'b0;
			busyN_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bootCnt_reg <= bootCnt_next;
			myId_reg <= myId_next;
			endian_reg <= endian_next;
			config_reg <= config_next;
			scratch_reg <= scratch_next;
			hiHalf_reg <= hiHalf_next;
			weDly_reg <= weDly_next;
			devOut_reg <= devOut_next;
			devOe_reg <= devOe_next;
			busyN_reg <= busyN_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	logic bootDone_reg, wide_reg;
	logic [15:0] scratchOut_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bootDone_reg <= 1'b0;
			wide_reg <= 1'b0;
			scratchOut_reg <= 16'h0000;
		end else begin
			bootDone_reg <= busyN_next;
			wide_reg <= config_next[CFG_WIDE_BIT];
			scratchOut_reg <= scratch_next;
		end
	end
	assign bootDone = bootDone_reg;
	assign wideMode = wide_reg;
	assign scratchWord = scratchOut_reg;
	assign bus.devDataOut = devOut_reg;
	assign bus.devDataOe = devOe_reg;
	assign bus.busyN = busyN_reg;
endmodule : flash_port_dev
`default_nettype wire

// File: host_bus_pkg.sv
// constants shared by both ends of the host port
// assumes nothing beyond a 50 MHz single clock
package host_bus_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int CLK_MHZ = 50;
	localparam int BOOT_COPY_NS = 2000;
	localparam int BOOT_COPY_CYC = (BOOT_COPY_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC = 2;
	localparam int HOST_TIMEOUT_CYC = 4000;
	// device-internal register offsets (word index on device address)
	localparam logic [7:0] OFS_ENDIAN = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h01;
	localparam logic [7:0] OFS_SCRATCH = 8'h02;
	localparam logic [7:0] OFS_STATUS = 8'h03;
	localparam logic [15:0] ENDIAN_RST = 16'h0000;
	localparam logic [15:0] CONFIG_RST = 16'h0000;
	localparam logic [15:0] SWAP_BITS = 16'h0101;
	localparam int CFG_WIDE_BIT = 0;
	// host command port offsets
	localparam logic [3:0] HOFS_ADDR = 4'h0;
	localparam logic [3:0] HOFS_WDATA = 4'h1;
	localparam logic [3:0] HOFS_CTRL = 4'h2;
	localparam logic [3:0] HOFS_STATUS = 4'h3;
	localparam logic [3:0] HOFS_RDATA = 4'h4;
	localparam int HCTL_GO = 0;
	localparam int HCTL_WRITE = 1;
	localparam int HCTL_WAITBUSY = 2;
	localparam int HCTL_ID = 3;
	localparam logic [15:0] BUSY_LOW_ON_IDLE = 16'h0000;
endpackage : host_bus_pkg

// File: host_bus_if.sv
// parallel host bus joining host and device ends
// resolves the data wire itself from the two enables
`timescale 1ns/10ps
`default_nettype none
interface host_bus_if;
	import host_bus_pkg::*;
	logic ceN;
	logic oeN;
	logic weN;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] hostDataOut;
	logic hostDataOe;
	logic [DATA_W-1:0] devDataOut;
	logic devDataOe;
	logic busyN;
	logic [DATA_W-1:0] dataLine;
	// resolved wire: the enabled end drives, host before device if both enable, else pulled high
	assign dataLine = hostDataOe ? hostDataOut : (devDataOe ? devDataOut : 16'hFFFF);
	modport host (output ceN, output oeN, output weN, output addr, output hostDataOut, output hostDataOe,
		input devDataOut, input devDataOe, input busyN, input dataLine);
	modport device (input ceN, input oeN, input weN, input addr, input hostDataOut, input hostDataOe,
		output devDataOut, output devDataOe, output busyN, input dataLine);
endinterface : host_bus_if
`default_nettype wire

// File: lane_swap.sv
// byte-lane steering between pins and the little-endian core
// assumes combinational use inside one clock domain
`timescale 1ns/10ps
`default_nettype none
module lane_swap
	import host_bus_pkg::*;
(
	input wire logic swapEn,
	input wire logic [DATA_W-1:0] dIn,
	output logic [DATA_W-1:0] dOut
);
	// lane 0 is bits 7:0 and least significant
	always_comb begin
		dOut = swapEn ? {dIn[7:0], dIn[15:8]} : dIn;
	end
endmodule : lane_swap
`default_nettype wire

// File: flash_port_host.sv
// host end: turns command-port writes into bus cycles
// assumes the device synchronises pins with two flops
`timescale 1ns/10ps
`default_nettype none
module flash_port_host
	import host_bus_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	host_bus_if.host bus,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata
);
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_WAITB = 4'b0010,
		H_CYC = 4'b0100,
		H_END = 4'b1000
	} host_state_e;

	logic [1:0] busySync_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			busySync_reg <= 2'h0;
		else
			busySync_reg <= {busySync_reg[0], bus.busyN};
	end

	host_state_e st_reg, st_next;
	logic [7:0] addr_reg, addr_next;
	logic [15:0] wdata_reg, wdata_next, rdata_reg, rdata_next, out_reg, out_next;
	logic [3:0] ctrl_reg, ctrl_next;
	logic [3:0] cnt_reg, cnt_next;
	logic ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next, dOe_reg, dOe_next;

	always_comb begin
		st_next = st_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		cnt_next = cnt_reg;
		ce_next = ce_reg;
		oe_next = oe_reg;
		we_next = we_reg;
		dOe_next = dOe_reg;
		out_next = 16'h0000;
		if (regRd) begin
			unique case (regAddr)
				HOFS_ADDR: out_next = {8'h00, addr_reg};
				HOFS_WDATA: out_next = wdata_reg;
				HOFS_CTRL: out_next = {12'h000, ctrl_reg};
				HOFS_STATUS: out_next = {14'h0000, busySync_reg[1], st_reg != H_IDLE};
				HOFS_RDATA: out_next = rdata_reg;
				default: out_next = 16'h0000;
			endcase
		end
		if (regWr && st_reg == H_IDLE) begin
			unique case (regAddr)
				HOFS_ADDR: addr_next = regWdata[7:0];
				HOFS_WDATA: wdata_next = regWdata;
				HOFS_CTRL: ctrl_next = regWdata[3:0];
				default: ;
			endcase
		end
		unique case (st_reg)
			H_IDLE: if (ctrl_reg[HCTL_GO]) begin
				addr_next[ADDR_W-1] = ctrl_reg[HCTL_ID];
				st_next = ctrl_reg[HCTL_WAITBUSY] ? H_WAITB : H_CYC;
				cnt_next = 4'h0;
			end
			H_WAITB: if (busySync_reg[1]) st_next = H_CYC;
			H_CYC: begin
				// fixed strobe length, no wait pin on this bus
				ce_next = 1'b0;
				oe_next = ctrl_reg[HCTL_WRITE];
				we_next = !ctrl_reg[HCTL_WRITE];
				dOe_next = ctrl_reg[HCTL_WRITE];
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == 4'(ACC_CYC + 4)) begin
					rdata_next = bus.dataLine;
					st_next = H_END;
				end
			end
			H_END: begin
				ce_next = 1'b1;
				oe_next = 1'b1;
				we_next = 1'b1;
				dOe_next = 1'b0;
				ctrl_next[HCTL_GO] = 1'b0;
				st_next = H_IDLE;
			end
			default: st_next = H_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= H_IDLE;
			addr_reg <= 8'h00;
			wdata_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
			out_reg <= 16'h0000;
			ctrl_reg <= 4'h0;
			cnt_reg <= 4'h0;
			ce_reg <= 1'b1;
			oe_reg <= 1'b1;
			we_reg <= 1'b1;
			dOe_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			out_reg <= out_next;
			ctrl_reg <= ctrl_next;
			cnt_reg <= cnt_next;
			ce_reg <= ce_next;
			oe_reg <= oe_next;
			we_reg <= we_next;
			dOe_reg <= dOe_next;
		end
	end
	assign regRdata = out_reg;
	assign bus.ceN = ce_reg;
	assign bus.oeN = oe_reg;
	assign bus.weN = we_reg;
	assign bus.addr = addr_reg;
	assign bus.hostDataOut = wdata_reg;
	assign bus.hostDataOe = dOe_reg;
endmodule : flash_port_host
`default_nettype wire

// File: host_bus_config_status_props.sv
// bus-level assertions for the host port wires
// assumes the bench instantiates it beside the interface
`timescale 1ns/10ps
`default_nettype none
module host_bus_config_status_props
	import host_bus_pkg::*;
#(
	parameter int BOOT_CYC = BOOT_COPY_CYC
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ceN,
	input wire logic oeN,
	input wire logic weN,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic hostDataOe,
	input wire logic devDataOe,
	input wire logic busyN,
	input wire logic identityStrap
);
	// slack for the pin synchronisers
	localparam int BOOT_MAX = BOOT_CYC + 4;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	a_busy_after_reset: assert property ($rose(resetn) |-> !busyN [*3] ##[1:BOOT_MAX] busyN)
		else $error("busy not released after boot");
	a_busy_no_return: assert property (busyN |=> busyN)
		else $error("busy came back after boot");
	a_quiet_in_boot: assert property (!busyN |-> !devDataOe)
		else $error("device drove data during boot");
	a_no_contention: assert property (!(devDataOe && hostDataOe))
		else $error("both ends drive data");
	a_own_identity: assert property ($rose(devDataOe) |-> !ceN && !oeN && addr[7] == identityStrap)
		else $error("device drove without own read");
	a_read_answer: assert property ($fell(oeN) && !ceN && busyN && addr[7] == identityStrap |-> ##[2:4] devDataOe)
		else $error("read not answered in time");
	a_strobe_length: assert property ($fell(ceN) |-> !ceN [*7] ##1 ceN)
		else $error("strobe length wrong");
	a_release_float: assert property ($rose(oeN) |-> ##[0:4] !devDataOe)
		else $error("data not released after read");
	a_word_write: assert property ($fell(weN) |-> !ceN && hostDataOe)
		else $error("write without full word");
endmodule : host_bus_config_status_props
`default_nettype wire

// File: host_bus_config_status_tb_top.sv
// bench joining host and device ends over the interface
// assumes a short boot count to keep the run brief
`timescale 1ns/10ps
`default_nettype none
module host_bus_config_status_tb_top
	import host_bus_pkg::*;
;
	localparam int BOOT_SIM = 5;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic identityStrap = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdata;
	logic bootDone;
	logic wideMode;
	logic [15:0] scratchWord;
	logic [15:0] got;
	int n_mismatch = 0;
	int checks_done = 0;
	always #10 clk = ~clk;
	host_bus_if hbus();
	flash_port_host i_flash_port_host(.clk(clk), .resetn(resetn), .bus(hbus), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
	flash_port_dev #(.BOOT_CYC(BOOT_SIM)) i_flash_port_dev(.clk(clk), .resetn(resetn), .bus(hbus),
		.identityStrap(identityStrap), .bootDone(bootDone), .wideMode(wideMode), .scratchWord(scratchWord));
	host_bus_config_status_props #(.BOOT_CYC(BOOT_SIM)) i_props(.clk(clk), .resetn(resetn), .ceN(hbus.ceN),
		.oeN(hbus.oeN), .weN(hbus.weN), .addr(hbus.addr), .hostDataOe(hbus.hostDataOe),
		.devDataOe(hbus.devDataOe), .busyN(hbus.busyN), .identityStrap(identityStrap));
	////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic do_reset(input logic strap);
		@(posedge clk);
		identityStrap <= strap;
		resetn <= 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		// look away from the edge that updates the outputs
		@(negedge clk);
	endtask : do_reset
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		got = regRdata;
	endtask : rd
	// always waits on busy, so early calls are safe
	task automatic cyc(input logic id, input logic [7:0] ofs, input logic wrt, input logic [15:0] d);
		wr(HOFS_ADDR, {8'h00, ofs});
		wr(HOFS_WDATA, d);
		wr(HOFS_CTRL, {12'h000, id, 1'b1, wrt, 1'b1});
		repeat (2) @(posedge clk);
		for (int i = 0; i < 200; i++) begin
			rd(HOFS_STATUS);
			if (got[0] === 1'b0) break;
		end
		chk("cycle done", {15'h0000, got[0]}, 16'h0000);
		rd(HOFS_RDATA);
	endtask : cyc
	////////////////////////////////////////
	task automatic t_boot();
		chk("busy at release", {15'h0000, hbus.busyN}, 16'h0000);
		cyc(1'b0, OFS_SCRATCH, 1'b1, 16'h1234);
		chk("scratch write", scratchWord, 16'h1234);
		rd(HOFS_STATUS);
		chk("synced busy", {15'h0000, got[1]}, 16'h0001);
		chk("boot done", {15'h0000, bootDone}, 16'h0001);
	endtask : t_boot
	task automatic t_lanes();
		cyc(1'b0, OFS_SCRATCH, 1'b0, 16'h0000);
		chk("word read", got, 16'h1234);
		cyc(1'b0, OFS_ENDIAN, 1'b1, SWAP_BITS);
		cyc(1'b0, OFS_SCRATCH, 1'b0, 16'h0000);
		chk("swapped read", got, 16'h3412);
		cyc(1'b0, OFS_SCRATCH, 1'b1, 16'hA1B2);
		chk("swapped write", scratchWord, 16'hB2A1);
		cyc(1'b0, OFS_ENDIAN, 1'b1, 16'h0000);
		cyc(1'b0, OFS_SCRATCH, 1'b0, 16'h0000);
		chk("lanes restored", got, 16'hB2A1);
	endtask : t_lanes
	// address bit 2 stands in for the host's second address line
	task automatic t_wide();
		chk("wide default", {15'h0000, wideMode}, 16'h0000);
		cyc(1'b0, OFS_CONFIG, 1'b1, 16'h0001);
		chk("wide set", {15'h0000, wideMode}, 16'h0001);
		cyc(1'b0, OFS_CONFIG, 1'b0, 16'h0000);
		chk("config read", got, 16'h0001);
		cyc(1'b0, OFS_SCRATCH | 8'h04, 1'b1, 16'h7E81);
		chk("high half apart", scratchWord, 16'hB2A1);
		cyc(1'b0, OFS_SCRATCH | 8'h04, 1'b0, 16'h0000);
		chk("high half read", got, 16'h7E81);
		cyc(1'b0, OFS_SCRATCH, 1'b0, 16'h0000);
		chk("low half read", got, 16'hB2A1);
		cyc(1'b0, OFS_CONFIG, 1'b1, 16'h0000);
		chk("wide clear", {15'h0000, wideMode}, 16'h0000);
		cyc(1'b0, OFS_SCRATCH | 8'h04, 1'b0, 16'h0000);
		chk("narrow alias", got, 16'hB2A1);
	endtask : t_wide
	task automatic t_other();
		cyc(1'b1, OFS_SCRATCH, 1'b1, 16'h5555);
		chk("foreign write", scratchWord, 16'hB2A1);
		cyc(1'b1, OFS_SCRATCH, 1'b0, 16'h0000);
		chk("foreign read", got, 16'hFFFF);
		rd(4'hF);
		chk("unmapped", got, 16'h0000);
	endtask : t_other
	// strap only counts at boot, hence the second reset
	task automatic t_second();
		do_reset(1'b1);
		chk("busy again", {15'h0000, hbus.busyN}, 16'h0000);
		cyc(1'b1, OFS_SCRATCH, 1'b1, 16'h00C3);
		chk("second write", scratchWord, 16'h00C3);
		cyc(1'b0, OFS_SCRATCH, 1'b0, 16'h0000);
		chk("first id floats", got, 16'hFFFF);
		chk("busy stays off", {15'h0000, hbus.busyN}, 16'h0001);
	endtask : t_second
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////
	initial begin
		do_reset(1'b0);
		t_boot();
		t_lanes();
		t_wide();
		t_other();
		t_second();
		end_sim();
	end
	// about 20 bus cycles of some 20 clocks each
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end
endmodule : host_bus_config_status_tb_top
`default_nettype wire
